// File: include/eeprom_wdog_defs.vh
`ifndef EEPROM_WDOG_DEFS_VH
`define EEPROM_WDOG_DEFS_VH

// opcodes, shifted msb first
`define OP_SET_LATCH    8'h06
`define OP_SET_FLAG     8'h00
`define OP_CLR_LATCH    8'h04
`define OP_STATUS_READ  8'h05
`define OP_STATUS_WRITE 8'h01
`define OP_ARRAY_READ   8'h03
`define OP_ARRAY_WRITE  8'h02

// status register bit positions
`define SR_PROTECT_EN   7
`define SR_USER_FLAG    6
`define SR_WDOG_HI      5
`define SR_WDOG_LO      4
`define SR_LOCK_HI      3
`define SR_LOCK_LO      2
`define SR_WRITE_LATCH  1
`define SR_WIP          0

// reset values of the nonvolatile fields
`define RST_PROTECT_EN  1'b0
`define RST_WDOG_PERIOD 2'h0
`define RST_LOCK_LEVEL  2'h0

// watchdog period select codes
`define WDOG_SEL_LONG   2'h0
`define WDOG_SEL_MID    2'h1
`define WDOG_SEL_SHORT  2'h2
`define WDOG_SEL_OFF    2'h3

// array geometry
`define ADDR_BITS       13
`define PAGE_BITS       5
`define PAGE_BYTES      32

// times in milliseconds, clock rate in kHz
`define MCLK_KHZ        25000
`define WDOG_LONG_MS    1400
`define WDOG_MID_MS     600
`define WDOG_SHORT_MS   200
`define RST_HOLD_MS     100
`define PUR_HOLD_MS     100
`define WRITE_TIME_MS   5

`endif

// File: rtl/spi_eeprom_watchdog_control.v
`timescale 1ns/1ps
`include "eeprom_wdog_defs.vh"

// Overview of operation
// - opcodes 06 set latch, 00 set user flag, 04 clear latch and flag
// - opcode 05 reads status, 01 writes watchdog, lock and protect bits
// - opcode 03 reads array, 02 writes array, from the following address
// - opcodes travel msb first and are assembled in that order
// - period bits 00 1.4 s, 01 600 ms, 10 200 ms, 11 off
// - user flag is volatile, changed only by flag opcodes, cleared at power-up
// - write-protect low with protect-enable set rejects every status write
// - array read: select, read opcode, 16-bit address, then data shifts out
// - read address increments per byte and wraps from top to zero
// - raising chip select ends a read at that edge
// - status read opcode shifts out the eight status bits
// - after set-latch chip select must rise, else a following write is ignored
// - array write is opcode, 16-bit address, at least one data byte
// - page write wraps to page start and overwrites loaded data
// - writes need the latch; locked blocks never written; status bits per protect
// - write starts only if chip select rises right after a byte's bit 0
// - write-in-progress stays high during internal writes; status reads still work
// - reset pin is open drain, active low or high per variant
// - power-up: standby, output released, latch and flag clear, reset held
// - status bits 7..0: protect, flag, period hi/lo, lock hi/lo, latch, busy
// - watchdog fires when chip select idles past period; falling edge restarts
// - latch clears when a valid nonvolatile write completes
// - a page is 32 bytes

module spi_eeprom_watchdog_control #(
	parameter WDOG_CNT_LONG     = `WDOG_LONG_MS * `MCLK_KHZ,
	parameter WDOG_CNT_MID      = `WDOG_MID_MS * `MCLK_KHZ,
	parameter WDOG_CNT_SHORT    = `WDOG_SHORT_MS * `MCLK_KHZ,
	parameter RST_HOLD_CNT      = `RST_HOLD_MS * `MCLK_KHZ,
	parameter PUR_HOLD_CNT      = `PUR_HOLD_MS * `MCLK_KHZ,
	parameter WRITE_CNT         = `WRITE_TIME_MS * `MCLK_KHZ,
	parameter RESET_ACTIVE_HIGH = 0
)(
	input  wire mclk,
	input  wire reset_n,
	input  wire ce,
	input  wire cs_n,
	input  wire sck,
	input  wire si,
	input  wire wp_n,
	output reg  so,
	output reg  so_oe,
	output reg  rst_pin_o,
	output reg  rst_pin_oe
);

	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_OP   = 3'h1;
	localparam [2:0] ST_ADDR = 3'h2;
	localparam [2:0] ST_RD   = 3'h3;
	localparam [2:0] ST_SRD  = 3'h4;
	localparam [2:0] ST_SWR  = 3'h5;
	localparam [2:0] ST_WD   = 3'h6;
	localparam [2:0] ST_IGN  = 3'h7;

	// pin synchronisers; cs resets low so a select held since power-up is no edge
	reg cs_n_m, cs_n_s, cs_n_p;
	reg sck_m, sck_s, sck_p;
	reg si_m, si_s;
	reg wp_n_m, wp_n_s;

	reg [2:0]  state_r;
	reg [2:0]  bit_r;
	reg [7:0]  sh_r;
	reg [7:0]  out_r;
	reg        addr_hi_r;
	reg        is_wr_r;
	reg        got_data_r;
	reg [12:0] addr_r;
	reg [7:0]  wpage_r;
	reg [31:0] page_ld_r;
	reg        wel_r;
	reg        flag_r;
	reg        protect_enable_r;
	reg [1:0]  wd_r;
	reg [1:0]  bl_r;
	reg        wip_r;
	reg        wkind_r;
	reg [7:0]  sr_new_r;
	reg [31:0] wcnt_r;

	reg [7:0] mem [0:(1 << `ADDR_BITS) - 1];
	reg [7:0] page_buf [0:`PAGE_BYTES - 1];

	wire       cs_fall  = cs_n_p & ~cs_n_s;
	wire       cs_rise  = ~cs_n_p & cs_n_s;
	wire       sck_rise = ~sck_p & sck_s & ~cs_n_s;
	wire       sck_fall = sck_p & ~sck_s & ~cs_n_s;
	wire [7:0] byte_in  = {sh_r[6:0], si_s};
	wire       byte_end = sck_rise & (bit_r == 3'h7);
	wire [12:0] addr_full = {addr_r[4:0], byte_in};
	wire [12:0] addr_inc  = addr_r + 13'h1;
	wire       wr_done  = wip_r & (wcnt_r == 32'h0);
	wire [7:0] status   = {protect_enable_r, flag_r, wd_r, bl_r, wel_r, wip_r};
	wire       sr_open  = ~protect_enable_r | wp_n_s;
	wire       wdog_rst;

	function page_locked;
		input [7:0] page;
		input [1:0] lvl;
		begin
			case (lvl)
				2'h1:    page_locked = (page[7:6] == 2'h3);
				2'h2:    page_locked = page[7];
				2'h3:    page_locked = 1'b1;
				default: page_locked = 1'b0;
			endcase
		end
	endfunction

	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cs_n_m  <= 1'b0;
			cs_n_s  <= 1'b0;
			cs_n_p  <= 1'b0;
			sck_m   <= 1'b0;
			sck_s   <= 1'b0;
			sck_p   <= 1'b0;
			si_m    <= 1'b0;
			si_s    <= 1'b0;
			wp_n_m  <= 1'b1;
			wp_n_s  <= 1'b1;
		end else if (ce) begin
			cs_n_m  <= cs_n;
			cs_n_s  <= cs_n_m;
			cs_n_p  <= cs_n_s;
			sck_m   <= sck;
			sck_s   <= sck_m;
			sck_p   <= sck_s;
			si_m    <= si;
			si_s    <= si_m;
			wp_n_m  <= wp_n;
			wp_n_s  <= wp_n_m;
		end
	end

	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state_r    <= ST_IDLE;
			bit_r      <= 3'h0;
			sh_r       <= 8'h0;
			out_r      <= 8'h0;
			addr_hi_r  <= 1'b0;
			is_wr_r    <= 1'b0;
			got_data_r <= 1'b0;
			addr_r     <= 13'h0;
			wpage_r    <= 8'h0;
			page_ld_r  <= 32'h0;
			wel_r      <= 1'b0;
			flag_r     <= 1'b0;
			protect_enable_r     <= `RST_PROTECT_EN;
			wd_r       <= `RST_WDOG_PERIOD;
			bl_r       <= `RST_LOCK_LEVEL;
			wip_r      <= 1'b0;
			wkind_r    <= 1'b0;
			sr_new_r   <= 8'h0;
			wcnt_r     <= 32'h0;
			so         <= 1'b0;
			so_oe      <= 1'b0;
		end else if (ce) begin
			if (cs_fall) begin
				// only a falling select opens a command
				state_r <= ST_OP;
				bit_r   <= 3'h0;
			end else if (cs_rise) begin
				// a rise at any other bit count drops the write
				if (state_r == ST_WD && got_data_r && bit_r == 3'h0 && wel_r &&
				    !page_locked(wpage_r, bl_r)) begin
					wip_r   <= 1'b1;
					wkind_r <= 1'b0;
					wcnt_r  <= WRITE_CNT - 1;
				end
				if (state_r == ST_SWR && got_data_r && bit_r == 3'h0 && wel_r &&
				    sr_open) begin
					wip_r   <= 1'b1;
					wkind_r <= 1'b1;
					wcnt_r  <= WRITE_CNT - 1;
				end
				state_r <= ST_IDLE;
			end else if (sck_rise) begin
				sh_r  <= byte_in;
				bit_r <= bit_r + 3'h1;
				if (bit_r == 3'h7) begin
					case (state_r)
						ST_OP: begin
							if (wip_r && byte_in != `OP_STATUS_READ) begin
								state_r <= ST_IGN;
							end else begin
								case (byte_in)
									`OP_SET_LATCH: begin
										wel_r   <= 1'b1;
										state_r <= ST_IGN;
									end
									`OP_SET_FLAG: begin
										flag_r  <= 1'b1;
										state_r <= ST_IGN;
									end
									`OP_CLR_LATCH: begin
										wel_r   <= 1'b0;
										flag_r  <= 1'b0;
										state_r <= ST_IGN;
									end
									`OP_STATUS_READ: begin
										out_r   <= status;
										state_r <= ST_SRD;
									end
									`OP_STATUS_WRITE: begin
										got_data_r <= 1'b0;
										state_r    <= ST_SWR;
									end
									`OP_ARRAY_READ: begin
										is_wr_r   <= 1'b0;
										addr_hi_r <= 1'b1;
										state_r   <= ST_ADDR;
									end
									`OP_ARRAY_WRITE: begin
										is_wr_r   <= 1'b1;
										addr_hi_r <= 1'b1;
										state_r   <= ST_ADDR;
									end
									default: state_r <= ST_IGN;
								endcase
							end
						end
						ST_ADDR: begin
							if (addr_hi_r) begin
								// unused high bits are zero from the host
								addr_r    <= {5'h0, byte_in};
								addr_hi_r <= 1'b0;
							end else if (is_wr_r) begin
								addr_r     <= addr_full;
								wpage_r    <= addr_full[12:5];
								page_ld_r  <= 32'h0;
								got_data_r <= 1'b0;
								state_r    <= ST_WD;
							end else begin
								addr_r  <= addr_full;
								out_r   <= mem[addr_full];
								state_r <= ST_RD;
							end
						end
						ST_RD: begin
							// 13-bit counter rolls from the top to zero
							addr_r <= addr_inc;
							out_r  <= mem[addr_inc];
						end
						ST_SRD: out_r <= status;
						ST_SWR: begin
							sr_new_r   <= byte_in;
							got_data_r <= 1'b1;
							// a second byte makes the frame invalid
							if (got_data_r)
								state_r <= ST_IGN;
						end
						ST_WD: begin
							page_ld_r[addr_r[4:0]] <= 1'b1;
							// offset wraps inside the page
							addr_r[4:0] <= addr_r[4:0] + 5'h1;
							got_data_r  <= 1'b1;
						end
						default: state_r <= state_r;
					endcase
				end
			end
			if (sck_fall && (state_r == ST_RD || state_r == ST_SRD)) begin
				so    <= out_r[7];
				out_r <= {out_r[6:0], 1'b0};
			end
			so_oe <= ~cs_n_s & (state_r == ST_RD || state_r == ST_SRD);
			if (wip_r) begin
				wcnt_r <= wcnt_r - 32'h1;
				if (wr_done) begin
					wip_r  <= 1'b0;
					wel_r  <= 1'b0;
					wcnt_r <= 32'h0;
					if (wkind_r) begin
						protect_enable_r <= sr_new_r[`SR_PROTECT_EN];
						wd_r   <= sr_new_r[`SR_WDOG_HI:`SR_WDOG_LO];
						bl_r   <= sr_new_r[`SR_LOCK_HI:`SR_LOCK_LO];
					end
				end
			end
		end
	end

	// array and page buffer are data only; no reset, like the cells they model
	integer i;
	always @(posedge mclk) begin
		if (ce && byte_end && state_r == ST_WD && !cs_n_s)
			page_buf[addr_r[4:0]] <= byte_in;
		if (ce && wr_done && !wkind_r) begin
			for (i = 0; i < `PAGE_BYTES; i = i + 1) begin
				if (page_ld_r[i])
					mem[{wpage_r, i[4:0]}] <= page_buf[i];
			end
		end
	end

	wdog_timer #(
		.CNT_LONG  (WDOG_CNT_LONG),
		.CNT_MID   (WDOG_CNT_MID),
		.CNT_SHORT (WDOG_CNT_SHORT),
		.RST_HOLD  (RST_HOLD_CNT),
		.PUR_HOLD  (PUR_HOLD_CNT)
	) u_wdog (
		.mclk       (mclk),
		.reset_n    (reset_n),
		.ce         (ce),
		.kick       (cs_fall),
		.period_sel (wd_r),
		.rst_active (wdog_rst)
	);

	// open drain: pin only ever pulled low, the pull-up gives the high level
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rst_pin_o  <= 1'b0;
			rst_pin_oe <= (RESET_ACTIVE_HIGH == 0);
		end else if (ce) begin
			rst_pin_o  <= 1'b0;
			rst_pin_oe <= (RESET_ACTIVE_HIGH == 0) ? wdog_rst : ~wdog_rst;
		end
	end

endmodule

// File: rtl/wdog_timer.v
`timescale 1ns/1ps
`include "eeprom_wdog_defs.vh"

module wdog_timer #(
	parameter CNT_LONG  = `WDOG_LONG_MS * `MCLK_KHZ,
	parameter CNT_MID   = `WDOG_MID_MS * `MCLK_KHZ,
	parameter CNT_SHORT = `WDOG_SHORT_MS * `MCLK_KHZ,
	parameter RST_HOLD  = `RST_HOLD_MS * `MCLK_KHZ,
	parameter PUR_HOLD  = `PUR_HOLD_MS * `MCLK_KHZ
)(
	input  wire       mclk,
	input  wire       reset_n,
	input  wire       ce,
	input  wire       kick,
	input  wire [1:0] period_sel,
	output reg        rst_active
);

	reg [31:0] cnt_r;
	reg [31:0] hold_r;

	function [31:0] limit;
		input [1:0] sel;
		begin
			case (sel)
				`WDOG_SEL_LONG:  limit = CNT_LONG;
				`WDOG_SEL_MID:   limit = CNT_MID;
				default:         limit = CNT_SHORT;
			endcase
		end
	endfunction

	// runs on mclk, so it keeps counting while the serial clock is idle
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_r      <= 32'h0;
			hold_r     <= PUR_HOLD;
			rst_active <= 1'b1;
		end else if (ce) begin
			if (hold_r != 32'h0) begin
				// power-up hold or timeout pulse; kicks are not seen here
				hold_r     <= hold_r - 32'h1;
				rst_active <= 1'b1;
				cnt_r      <= 32'h0;
			end else begin
				rst_active <= 1'b0;
				if (period_sel == `WDOG_SEL_OFF || kick) begin
					cnt_r <= 32'h0;
				end else if (cnt_r >= limit(period_sel) - 32'h1) begin
					hold_r     <= RST_HOLD;
					rst_active <= 1'b1;
					cnt_r      <= 32'h0;
				end else begin
					cnt_r <= cnt_r + 32'h1;
				end
			end
		end
	end

endmodule

// File: sim/spi_eeprom_watchdog_control_props.sv
`timescale 1ns/1ps
module spi_eeprom_watchdog_control_props #(
	parameter WDOG_CNT_SHORT    = 800,
	parameter RESET_ACTIVE_HIGH = 0
)(
	input wire mclk,
	input wire reset_n,
	input wire ce,
	input wire cs_n,
	input wire sck,
	input wire si,
	input wire wp_n,
	input wire so,
	input wire so_oe,
	input wire rst_pin_o,
	input wire rst_pin_oe
);
	logic [15:0] idle_r;
	logic        cs_q_r;
	wire         rst_on = rst_pin_oe ^ (RESET_ACTIVE_HIGH != 0);

	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);

	// saturating count since the last chip-select fall, the only watchdog kick
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cs_q_r <= 1'b1;
			idle_r <= 16'h0000;
		end else begin
			cs_q_r <= cs_n;
			idle_r <= (cs_q_r && !cs_n) ? 16'h0000 : idle_r + {15'h0000, ~&idle_r};
		end
	end

	chk_pin_value: assert property (!rst_pin_o)
		else $error("reset pin value not low");
	chk_pur_hold: assert property ($rose(reset_n) |-> rst_on[*8])
		else $error("power-up reset not held");
	chk_rst_hold: assert property ($rose(rst_on) |-> rst_on[*8])
		else $error("reset pulse too short");
	chk_wdog_idle: assert property ($rose(rst_on) |-> idle_r >= WDOG_CNT_SHORT - 5)
		else $error("watchdog fired too early");
	chk_oe_idle: assert property (cs_n[*8] |-> !so_oe)
		else $error("output driven while deselected");
	chk_oe_late: assert property ($fell(cs_n) |-> ##6 (!so_oe)[*8])
		else $error("output driven before opcode done");
	chk_so_stable: assert property (sck[*3] ##0 (so_oe && $past(so_oe)) |-> $stable(so))
		else $error("output changed while clock high");
	chk_ce_freeze: assert property (!ce |=> $stable(so) && $stable(so_oe) && $stable(rst_pin_oe))
		else $error("outputs moved with enable low");
endmodule

bind spi_eeprom_watchdog_control spi_eeprom_watchdog_control_props #(
	.WDOG_CNT_SHORT(WDOG_CNT_SHORT), .RESET_ACTIVE_HIGH(RESET_ACTIVE_HIGH)
) props_i (
	.mclk(mclk), .reset_n(reset_n), .ce(ce), .cs_n(cs_n), .sck(sck), .si(si),
	.wp_n(wp_n), .so(so), .so_oe(so_oe), .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe)
);

// File: sim/spi_eeprom_watchdog_control_tb_top.sv
`timescale 1ns/1ps
module spi_eeprom_watchdog_control_tb_top;
	logic       mclk = 1'b0;
	logic       reset_n = 1'b0;
	logic       ce = 1'b1;
	logic       wp_n = 1'b1;
	wire        cs_n, sck, si, so, so_oe, rst_pin_o, rst_pin_oe;
	int         err_total = 0;
	int         checks = 0;
	int         n;
	logic [7:0] rx, s;
	logic [7:0] ops [3] = '{8'h00, 8'h06, 8'h04};
	logic [7:0] exps [3] = '{8'h40, 8'h42, 8'h00};

	always #20 mclk = ~mclk;

	spi_host_model host (.mclk(mclk), .so(so), .so_oe(so_oe), .cs_n(cs_n), .sck(sck), .si(si));

	// long period and active-low variant stay at their defaults
	spi_eeprom_watchdog_control #(
		.WDOG_CNT_MID(1200), .WDOG_CNT_SHORT(800), .RST_HOLD_CNT(20),
		.PUR_HOLD_CNT(20), .WRITE_CNT(400)
	) uut (
		.mclk(mclk), .reset_n(reset_n), .ce(ce), .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n),
		.so(so), .so_oe(so_oe), .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe)
	);

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d, mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic cmd(input logic [7:0] op);
		host.sel();
		host.xbyte(op, rx);
		host.desel();
	endtask
	task automatic rd_status;
		host.sel();
		host.xbyte(8'h05, rx);
		host.xbyte(8'h00, s);
		host.desel();
	endtask
	task automatic addr(input logic [7:0] op, input logic [15:0] a);
		host.sel();
		host.xbyte(op, rx);
		host.xbyte(a[15:8], rx);
		host.xbyte(a[7:0], rx);
	endtask
	task automatic wr_status(input logic [7:0] v);
		cmd(8'h06);
		host.sel();
		host.xbyte(8'h01, rx);
		host.xbyte(v, rx);
		host.desel();
	endtask
	task automatic wait_write(input logic [7:0] exp);
		rd_status();
		chk(s & 8'h01, 8'h01);
		for (n = 0; n < 8 && s[0] !== 1'b0; n++)
			rd_status();
		chk(s, exp);
	endtask

	initial begin
		repeat (3) @(negedge mclk);
		reset_n = 1'b1;
		@(negedge mclk);
		chk({7'h00, rst_pin_oe}, 8'h01);
		rd_status();
		chk(s, 8'h00);
		chk({7'h00, so_oe}, 8'h00);
		for (int i = 0; i < 3; i++) begin
			cmd(ops[i]);
			rd_status();
			chk(s, exps[i]);
		end
		addr(8'h02, 16'h0040);
		host.xbyte(8'h55, rx);
		host.desel();
		rd_status();
		chk(s, 8'h00);
		// latch opcode with select kept low: the write behind it must die
		host.sel();
		host.xbyte(8'h06, rx);
		host.xbyte(8'h02, rx);
		host.xbyte(8'h00, rx);
		host.xbyte(8'h40, rx);
		host.xbyte(8'h55, rx);
		host.desel();
		rd_status();
		chk(s, 8'h02);
		addr(8'h02, 16'h0080);
		host.xbyte(8'haa, rx);
		repeat (3) host.xbit(1'b1, rx[0]);
		host.desel();
		rd_status();
		chk(s, 8'h02);
		cmd(8'h06);
		addr(8'h02, 16'h001f);
		host.xbyte(8'ha1, rx);
		host.xbyte(8'ha2, rx);
		host.desel();
		wait_write(8'h00);
		cmd(8'h06);
		addr(8'h02, 16'h1fff);
		host.xbyte(8'ha3, rx);
		host.desel();
		wait_write(8'h00);
		addr(8'h03, 16'h1fff);
		host.xbyte(8'h00, s);
		chk(s, 8'ha3);
		host.xbyte(8'h00, s);
		chk(s, 8'ha2);
		host.desel();
		// clock idling high: the byte loaded at the page's last offset
		host.set_mode(1'b1);
		addr(8'h03, 16'h001f);
		host.xbyte(8'h00, s);
		chk(s, 8'ha1);
		host.desel();
		host.set_mode(1'b0);
		wr_status(8'h8c);
		wait_write(8'h8c);
		wp_n = 1'b0;
		wr_status(8'h30);
		rd_status();
		chk(s, 8'h8e);
		addr(8'h02, 16'h0100);
		host.xbyte(8'h77, rx);
		host.desel();
		rd_status();
		chk(s, 8'h8e);
		wp_n = 1'b1;
		wr_status(8'h30);
		wait_write(8'h30);
		repeat (2500) @(negedge mclk);
		chk({7'h00, rst_pin_oe}, 8'h00);
		ce = 1'b0;
		repeat (4) @(negedge mclk);
		ce = 1'b1;
		wr_status(8'h20);
		wait_write(8'h20);
		// short period must fire well before the mid one could
		for (n = 0; n < 3000 && rst_pin_oe !== 1'b1; n++)
			@(negedge mclk);
		chk({7'h00, n > 550 && n < 800}, 8'h01);
		give_verdict();
	end

	initial begin
		repeat (30000) @(posedge mclk);
		err_total++;
		$display("mismatch at %0t: run timed out", $time);
		give_verdict();
	end
endmodule

// File: sim/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
	input  wire mclk,
	input  wire so,
	input  wire so_oe,
	output reg  cs_n,
	output reg  sck,
	output reg  si
);
	logic cpol;

	initial begin
		cpol = 1'b0;
		cs_n = 1'b1;
		sck  = 1'b0;
		si   = 1'b0;
	end
	task automatic gap(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic sel;
		gap(8);
		cs_n = 1'b0;
		gap(4);
	endtask
	task automatic desel;
		gap(4);
		cs_n = 1'b1;
		si   = ~si; // released line must not keep stale data
		gap(8);
	endtask
	// only while deselected, so the idle level change is no clock edge
	task automatic set_mode(input logic p);
		cpol = p;
		sck  = p;
		gap(8);
	endtask
	// mode 0 idles low, mode 3 idles high; 4 mclk per half period
	task automatic xbit(input logic b, output logic r);
		if (cpol)
			sck = 1'b0;
		si = b;
		gap(4);
		r = so_oe ? so : 1'bx;
		sck = 1'b1;
		gap(4);
		if (!cpol)
			sck = 1'b0;
	endtask
	task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--)
			xbit(tx[i], rx[i]);
	endtask
endmodule
